// *** src/crf_defines.vh ***
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// register word offsets on the bus (byte addresses)
`define CRF_OFF_IAC 8'h00
`define CRF_OFF_ACC 8'h04
`define CRF_OFF_TMP 8'h08
`define CRF_OFF_IDX 8'h0C
`define CRF_OFF_AUX 8'h10
`define CRF_OFF_STK 8'h14
`define CRF_OFF_PSW 8'h18
`define CRF_OFF_GRA 8'h1C

// condition code byte layout
`define CRF_CC_C 0
`define CRF_CC_V 1
`define CRF_CC_Z 2
`define CRF_CC_N 3
`define CRF_CC_IL_LO 4
`define CRF_CC_IL_HI 5
`define CRF_CC_I 6
`define CRF_CC_H 7

// reset values
`define CRF_RST_WORD 16'h0000
`define CRF_RST_IL 2'h3
`define CRF_RST_BANK 8'h00

// datapath flag update operations
`define CRF_OP_NONE 3'h0
`define CRF_OP_ADD8 3'h1
`define CRF_OP_SUB8 3'h2
`define CRF_OP_SHL8 3'h3
`define CRF_OP_SHR8 3'h4
`define CRF_OP_ADD16 3'h5
`define CRF_OP_SUB16 3'h6

// register write selects from the decoder
`define CRF_SEL_IAC 3'h0
`define CRF_SEL_ACC 3'h1
`define CRF_SEL_TMP 3'h2
`define CRF_SEL_IDX 3'h3
`define CRF_SEL_AUX 3'h4
`define CRF_SEL_STK 3'h5
`define CRF_SEL_PSW 3'h6

// bank base: 8 registers per bank, 32 banks, base window
`define CRF_BANK_BASE 16'h0100
`define CRF_BANK_MASK 8'h1F

`endif

// *** src/crf_regfile.v ***
// Contract
// RQ1 - 16-bit counter holds next fetch address
// RQ2 - 16-bit main accumulator, bytes use low
// RQ3 - 16-bit temporary accumulator, second operand
// RQ4 - 16-bit index register modifies addresses
// RQ5 - 16-bit auxiliary pointer holds memory address
// RQ6 - 16-bit stack pointer locates stack
// RQ7 - status word: bank pointer high, codes low
// RQ8 - bank pointer selects general register bank
// RQ9 - half-carry from bit 3 into 4
// RQ10 - interrupt enable flag, resets to zero
// RQ11 - level field, only stronger requests serviced
// RQ12 - negative copies result top bit
// RQ13 - zero flag set on zero result
// RQ14 - overflow flag on signed overflow
// RQ15 - carry flag from bit 7
// RQ16 - shifts put shifted-out bit in carry
// RQ17 - general registers 8-bit, in memory
// RQ18 - eight registers per bank, 32 banks
// RQ19 - address from bank base plus number
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "crf_defines.vh"

module crf_regfile (
	input wire mclk,
	input wire rst_b,
	// avalon-mm slave
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	output reg [1:0] avs_response,
	// core write port
	input wire core_we,
	input wire [2:0] core_sel,
	input wire [15:0] core_wdata,
	input wire core_inc_iac,
	// arithmetic datapath
	input wire [2:0] alu_op,
	input wire [15:0] alu_a,
	input wire [15:0] alu_b,
	input wire alu_cin,
	input wire alu_wb,
	output reg [15:0] alu_result,
	// interrupt gating
	input wire irq_valid,
	input wire [1:0] irq_level,
	output wire irq_take,
	input wire irq_ack,
	// general register addressing
	input wire [2:0] gr_num,
	output wire [15:0] gr_addr,
	// state views
	output wire [15:0] instruction_address_counter,
	output wire [15:0] main_accumulator,
	output wire [15:0] temporary_accumulator,
	output wire [15:0] index_register,
	output wire [15:0] auxiliary_pointer,
	output wire [15:0] stack_pointer,
	output wire [15:0] program_status_word
);

	reg [15:0] iac_r;
	reg [15:0] acc_r;
	reg [15:0] tmp_r;
	reg [15:0] idx_r;
	reg [15:0] aux_r;
	reg [15:0] stk_r;
	reg [7:0] bank_pointer_r;
	reg [7:0] ccb_r;
	reg ack_r;
	reg [7:0] ccb_nxt;
	reg [15:0] res_nxt;
	reg [16:0] sum17;
	reg [4:0] nib5;
	reg bus_wr_hit;
	reg flags_upd;

	// merge write data under byte enables for a 16-bit register
	function [15:0] crf_merge;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] be;
		begin
			crf_merge = old;
			if (be[0]) begin
				crf_merge[7:0] = wd[7:0];
			end
			if (be[1]) begin
				crf_merge[15:8] = wd[15:8];
			end
		end
	endfunction

	// zero test of either byte or word result
	function crf_is_zero;
		input [15:0] v;
		input wide;
		begin
			if (wide) begin
				crf_is_zero = (v == 16'h0000);
			end else begin
				crf_is_zero = (v[7:0] == 8'h00);
			end
		end
	endfunction

	// one wait state: read data registered on the first edge so it stands when waitrequest drops;
	// writes commit only on the edge where waitrequest is seen low, as the master expects
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

	assign instruction_address_counter = iac_r;
	assign main_accumulator = acc_r;
	assign temporary_accumulator = tmp_r;
	assign index_register = idx_r;
	assign auxiliary_pointer = aux_r;
	assign stack_pointer = stk_r;
	assign program_status_word = {bank_pointer_r, ccb_r}; // see RQ7

	// banked registers live in data memory; only the address is made here
	assign gr_addr = `CRF_BANK_BASE + {5'h00, (bank_pointer_r & `CRF_BANK_MASK), gr_num}; // see RQ8 see RQ17 see RQ18 see RQ19

	// 00 strongest; request must beat the current level
	assign irq_take = irq_valid & ccb_r[`CRF_CC_I] &
		(irq_level < ccb_r[`CRF_CC_IL_HI:`CRF_CC_IL_LO]); // see RQ10 see RQ11

	always @* begin
		ccb_nxt = ccb_r;
		res_nxt = 16'h0000;
		sum17 = 17'h00000;
		nib5 = 5'h00;
		flags_upd = 1'b1;
		case (alu_op)
			`CRF_OP_ADD8: begin
				sum17 = {9'h000, alu_a[7:0]} + {9'h000, alu_b[7:0]} + {16'h0000, alu_cin};
				nib5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
				res_nxt = {8'h00, sum17[7:0]}; // see RQ2 see RQ3
				ccb_nxt[`CRF_CC_H] = nib5[4]; // see RQ9
				ccb_nxt[`CRF_CC_C] = sum17[8]; // see RQ15
				ccb_nxt[`CRF_CC_V] = (alu_a[7] == alu_b[7]) & (sum17[7] != alu_a[7]); // see RQ14
				ccb_nxt[`CRF_CC_N] = sum17[7]; // see RQ12
				ccb_nxt[`CRF_CC_Z] = crf_is_zero(res_nxt, 1'b0); // see RQ13
			end
			`CRF_OP_SUB8: begin
				sum17 = {9'h000, alu_a[7:0]} - {9'h000, alu_b[7:0]} - {16'h0000, alu_cin};
				nib5 = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]} - {4'h0, alu_cin};
				res_nxt = {8'h00, sum17[7:0]};
				ccb_nxt[`CRF_CC_H] = nib5[4]; // see RQ9
				ccb_nxt[`CRF_CC_C] = sum17[8]; // see RQ15
				ccb_nxt[`CRF_CC_V] = (alu_a[7] != alu_b[7]) & (sum17[7] != alu_a[7]); // see RQ14
				ccb_nxt[`CRF_CC_N] = sum17[7]; // see RQ12
				ccb_nxt[`CRF_CC_Z] = crf_is_zero(res_nxt, 1'b0); // see RQ13
			end
			`CRF_OP_SHL8: begin
				res_nxt = {8'h00, alu_a[6:0], alu_cin};
				ccb_nxt[`CRF_CC_C] = alu_a[7]; // see RQ16
				ccb_nxt[`CRF_CC_N] = res_nxt[7];
				ccb_nxt[`CRF_CC_Z] = crf_is_zero(res_nxt, 1'b0);
			end
			`CRF_OP_SHR8: begin
				res_nxt = {8'h00, alu_cin, alu_a[7:1]};
				ccb_nxt[`CRF_CC_C] = alu_a[0]; // see RQ16
				ccb_nxt[`CRF_CC_N] = res_nxt[7];
				ccb_nxt[`CRF_CC_Z] = crf_is_zero(res_nxt, 1'b0);
			end
			`CRF_OP_ADD16: begin
				sum17 = {1'b0, alu_a} + {1'b0, alu_b} + {16'h0000, alu_cin};
				res_nxt = sum17[15:0];
				ccb_nxt[`CRF_CC_C] = sum17[16];
				ccb_nxt[`CRF_CC_V] = (alu_a[15] == alu_b[15]) & (sum17[15] != alu_a[15]); // see RQ14
				ccb_nxt[`CRF_CC_N] = sum17[15]; // see RQ12
				ccb_nxt[`CRF_CC_Z] = crf_is_zero(res_nxt, 1'b1); // see RQ13
			end
			`CRF_OP_SUB16: begin
				sum17 = {1'b0, alu_a} - {1'b0, alu_b} - {16'h0000, alu_cin};
				res_nxt = sum17[15:0];
				ccb_nxt[`CRF_CC_C] = sum17[16];
				ccb_nxt[`CRF_CC_V] = (alu_a[15] != alu_b[15]) & (sum17[15] != alu_a[15]); // see RQ14
				ccb_nxt[`CRF_CC_N] = sum17[15];
				ccb_nxt[`CRF_CC_Z] = crf_is_zero(res_nxt, 1'b1);
			end
			default: begin
				flags_upd = 1'b0;
			end
		endcase
		bus_wr_hit = avs_write & ack_r;
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			iac_r <= `CRF_RST_WORD;
			acc_r <= `CRF_RST_WORD;
			tmp_r <= `CRF_RST_WORD;
			idx_r <= `CRF_RST_WORD;
			aux_r <= `CRF_RST_WORD;
			stk_r <= `CRF_RST_WORD;
			bank_pointer_r <= `CRF_RST_BANK;
			ccb_r <= {1'b0, 1'b0, `CRF_RST_IL, 4'h0}; // see RQ10
			alu_result <= `CRF_RST_WORD;
			ack_r <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'h0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
			if (flags_upd) begin
				alu_result <= res_nxt;
			end
			// priority: core write, then bus, then interrupt, then alu writeback/flags
			if (core_inc_iac) begin
				iac_r <= iac_r + 16'h0001; // see RQ1
			end
			if (flags_upd) begin
				ccb_r <= ccb_nxt;
			end
			if (alu_wb && flags_upd) begin
				acc_r <= res_nxt; // see RQ2
			end
			if (irq_ack) begin
				ccb_r[`CRF_CC_I] <= 1'b0;
			end
			if (core_we) begin
				case (core_sel)
					`CRF_SEL_IAC: iac_r <= core_wdata; // see RQ1
					`CRF_SEL_ACC: acc_r <= core_wdata; // see RQ2
					`CRF_SEL_TMP: tmp_r <= core_wdata; // see RQ3
					`CRF_SEL_IDX: idx_r <= core_wdata; // see RQ4
					`CRF_SEL_AUX: aux_r <= core_wdata; // see RQ5
					`CRF_SEL_STK: stk_r <= core_wdata; // see RQ6
					`CRF_SEL_PSW: begin
						bank_pointer_r <= core_wdata[15:8]; // see RQ7
						ccb_r <= core_wdata[7:0];
					end
					default: begin
					end
				endcase
			end else if (bus_wr_hit) begin
				if (avs_address == `CRF_OFF_IAC) begin
					iac_r <= crf_merge(iac_r, avs_writedata, avs_byteenable);
				end else if (avs_address == `CRF_OFF_ACC) begin
					acc_r <= crf_merge(acc_r, avs_writedata, avs_byteenable);
				end else if (avs_address == `CRF_OFF_TMP) begin
					tmp_r <= crf_merge(tmp_r, avs_writedata, avs_byteenable);
				end else if (avs_address == `CRF_OFF_IDX) begin
					idx_r <= crf_merge(idx_r, avs_writedata, avs_byteenable); // see RQ4
				end else if (avs_address == `CRF_OFF_AUX) begin
					aux_r <= crf_merge(aux_r, avs_writedata, avs_byteenable); // see RQ5
				end else if (avs_address == `CRF_OFF_STK) begin
					stk_r <= crf_merge(stk_r, avs_writedata, avs_byteenable); // see RQ6
				end else if (avs_address == `CRF_OFF_PSW) begin
					if (avs_byteenable[0]) begin
						ccb_r <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						bank_pointer_r <= avs_writedata[15:8];
					end
				end
			end
			if (avs_read && !ack_r) begin
				avs_response <= 2'h0;
				if (avs_address == `CRF_OFF_IAC) begin
					avs_readdata <= {16'h0000, iac_r};
				end else if (avs_address == `CRF_OFF_ACC) begin
					avs_readdata <= {16'h0000, acc_r};
				end else if (avs_address == `CRF_OFF_TMP) begin
					avs_readdata <= {16'h0000, tmp_r};
				end else if (avs_address == `CRF_OFF_IDX) begin
					avs_readdata <= {16'h0000, idx_r};
				end else if (avs_address == `CRF_OFF_AUX) begin
					avs_readdata <= {16'h0000, aux_r};
				end else if (avs_address == `CRF_OFF_STK) begin
					avs_readdata <= {16'h0000, stk_r};
				end else if (avs_address == `CRF_OFF_PSW) begin
					avs_readdata <= {16'h0000, bank_pointer_r, ccb_r};
				end else if (avs_address == `CRF_OFF_GRA) begin
					avs_readdata <= {16'h0000, gr_addr};
				end else begin
					// unmapped: zero data with slave error
					avs_readdata <= 32'h0000_0000;
					avs_response <= 2'h2;
				end
			end else if (avs_write && !ack_r) begin
				avs_response <= 2'h0;
			end
		end
	end

endmodule

// *** verif/crf_regfile_properties.sv ***
`timescale 1ns/1ns
module crf_regfile_properties (
	input wire mclk,
	input wire rst_b,
	input wire core_we,
	input wire core_inc_iac,
	input wire [2:0] alu_op,
	input wire [15:0] alu_a,
	input wire [15:0] alu_b,
	input wire alu_cin,
	input wire alu_wb,
	input wire [15:0] alu_result,
	input wire irq_valid,
	input wire [1:0] irq_level,
	input wire irq_take,
	input wire irq_ack,
	input wire [2:0] gr_num,
	input wire [15:0] gr_addr,
	input wire [15:0] instruction_address_counter,
	input wire [15:0] main_accumulator,
	input wire [15:0] program_status_word
);
	wire [7:0] cc = program_status_word[7:0];
	// decoder writes win over flags, so keep them out of the antecedents
	wire add8 = alu_op == 3'h1 && !alu_cin && !core_we;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	AST_IRQ_GATE: assert property (irq_take == (irq_valid && cc[6] && irq_level < cc[5:4]))
		else $error("interrupt gate wrong");
	AST_BANK_ADDR: assert property (gr_addr == 16'h0100 + {8'h00, program_status_word[12:8], gr_num})
		else $error("bank address wrong");
	AST_ZN8: assert property (alu_op != 3'h0 && alu_op < 3'h5 && !core_we |=>
		cc[2] == (alu_result[7:0] == 8'h00) && cc[3] == alu_result[7]) else $error("zero or negative wrong");
	AST_CARRY8: assert property (add8 |=> {cc[0], alu_result[7:0]} == $past(alu_a[7:0]) + $past(alu_b[7:0]))
		else $error("byte add carry wrong");
	AST_HALF8: assert property (add8 |=> cc[7] == ($past(alu_a[3:0]) + $past(alu_b[3:0]) > 15))
		else $error("half carry wrong");
	AST_OVF8: assert property (add8 |=> cc[1] == ($past(alu_a[7]) == $past(alu_b[7]) && alu_result[7] != $past(alu_a[7])))
		else $error("overflow wrong");
	AST_SHL_C: assert property (alu_op == 3'h3 && !core_we |=> cc[0] == $past(alu_a[7]))
		else $error("shift carry wrong");
	AST_IAC_INC: assert property (core_inc_iac && !core_we |=>
		instruction_address_counter == $past(instruction_address_counter) + 16'h0001) else $error("counter step wrong");
	AST_ACC_WB: assert property (alu_wb && alu_op != 3'h0 && !core_we |=> main_accumulator == alu_result)
		else $error("accumulator writeback wrong");
	AST_IACK: assert property (irq_ack && !core_we |=> !cc[6])
		else $error("enable not cleared");
endmodule
bind crf_regfile crf_regfile_properties i_crf_regfile_properties (.*);

// *** verif/crf_core_model.sv ***
`timescale 1ns/1ns
module crf_core_model (
	input wire mclk,
	output reg core_we,
	output reg [2:0] core_sel,
	output reg [15:0] core_wdata,
	output reg core_inc_iac,
	output reg [2:0] alu_op,
	output reg [15:0] alu_a,
	output reg [15:0] alu_b,
	output reg alu_cin,
	output reg alu_wb,
	output reg irq_ack
);
	initial begin
		{core_we, core_sel, core_wdata, core_inc_iac, alu_op, alu_a, alu_b, alu_cin, alu_wb, irq_ack} = 0;
	end
	// one decoded step; released operands flip so stale values never look right
	task step(input [2:0] op, input [15:0] a, input [15:0] b, input cin, input we, input [2:0] sel, input inc,
		input ack);
		begin
			@(posedge mclk);
			alu_op <= op;
			alu_a <= a;
			alu_b <= b;
			alu_cin <= cin;
			alu_wb <= op != 3'h0;
			core_we <= we;
			core_sel <= sel;
			core_wdata <= a;
			core_inc_iac <= inc;
			irq_ack <= ack;
			@(posedge mclk);
			alu_op <= 3'h0;
			alu_a <= ~a;
			alu_b <= ~b;
			core_we <= 1'b0;
			core_inc_iac <= 1'b0;
			irq_ack <= 1'b0;
			@(negedge mclk);
		end
	endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	reg mclk = 0;
	reg rst_b = 0;
	reg [7:0] avs_address = 8'h00;
	reg avs_read = 0;
	reg avs_write = 0;
	reg [31:0] avs_writedata = 32'h0000_0000;
	reg [3:0] avs_byteenable = 4'h3;
	reg irq_valid = 0;
	reg [1:0] irq_level = 2'h0;
	reg [2:0] gr_num = 3'h0;
	wire [31:0] avs_readdata;
	wire [1:0] avs_response;
	wire avs_waitrequest, core_we, core_inc_iac, alu_cin, alu_wb, irq_ack, irq_take;
	wire [2:0] core_sel, alu_op;
	wire [15:0] core_wdata, alu_a, alu_b, alu_result, gr_addr, instruction_address_counter, main_accumulator;
	wire [15:0] temporary_accumulator, index_register, auxiliary_pointer, stack_pointer, program_status_word;
	integer num_errors = 0;
	integer n_checks = 0;
	integer i;
	reg [31:0] rd;
	reg [1:0] rsp;
	crf_regfile i_crf_regfile (.*);
	crf_core_model i_crf_core_model (.*);
	initial begin
		forever #50 mclk = ~mclk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task bus(input wr, input [7:0] a, input [15:0] d);
		integer n;
		begin
			@(posedge mclk);
			avs_address <= a;
			avs_writedata <= {16'h0000, d};
			avs_write <= wr;
			avs_read <= !wr;
			n = 0;
			@(posedge mclk);
			while (avs_waitrequest !== 1'b0 && n < 20) begin
				@(posedge mclk);
				n = n + 1;
			end
			chk(avs_waitrequest, 0);
			rd = avs_readdata;
			rsp = avs_response;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task report_and_stop;
		begin
			if (num_errors == 0 && n_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		#200000;
		num_errors = num_errors + 1;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		for (i = 0; i < 7; i = i + 1) begin
			bus(0, {i[5:0], 2'b00}, 16'h0000);
			chk(rd, i == 6 ? 32'h0000_0030 : 32'h0000_0000);
		end
		bus(0, 8'h20, 16'h0000);
		chk(rsp, 2'h2);
		// address view is read only
		bus(1, 8'h1C, 16'hFFFF);
		bus(0, 8'h1C, 16'h0000);
		chk(rd, 32'h0000_0100);
		for (i = 0; i < 6; i = i + 1) begin
			bus(1, {i[5:0], 2'b00}, 16'hA5C3 ^ i[15:0]);
			bus(0, {i[5:0], 2'b00}, 16'h0000);
			chk(rd, 16'hA5C3 ^ i[15:0]);
		end
		bus(1, 8'h18, 16'h2530);
		gr_num <= 3'h3;
		bus(0, 8'h18, 16'h0000);
		chk(rd, 32'h0000_2530);
		chk(gr_addr, 16'h012B);
		i_crf_core_model.step(3'h1, 16'h008F, 16'h0071, 0, 0, 3'h0, 0, 0);
		chk(program_status_word[7:0], 8'hB5);
		chk(main_accumulator[7:0], 8'h00);
		i_crf_core_model.step(3'h1, 16'h0040, 16'h0040, 0, 0, 3'h0, 0, 0);
		chk(program_status_word[7:0], 8'h3A);
		i_crf_core_model.step(3'h2, 16'h0010, 16'h0001, 0, 0, 3'h0, 0, 0);
		chk(program_status_word[7:0], 8'hB0);
		i_crf_core_model.step(3'h3, 16'h0081, 16'h0000, 0, 0, 3'h0, 0, 0);
		chk(program_status_word[0], 1);
		i_crf_core_model.step(3'h4, 16'h0002, 16'h0000, 1, 0, 3'h0, 0, 0);
		chk({program_status_word[0], alu_result[7:0]}, 9'h081);
		i_crf_core_model.step(3'h5, 16'hFFFF, 16'h0001, 0, 0, 3'h0, 0, 0);
		chk(program_status_word[2], 1);
		i_crf_core_model.step(3'h0, 16'h0060, 16'h0000, 0, 1, 3'h6, 0, 0);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge mclk);
			irq_valid <= 1'b1;
			irq_level <= i[1:0];
			@(negedge mclk);
			chk(irq_take, i < 2);
		end
		i_crf_core_model.step(3'h0, 16'h0000, 16'h0000, 0, 0, 3'h0, 0, 1);
		chk(program_status_word, 16'h0020);
		i_crf_core_model.step(3'h0, 16'hFFFF, 16'h0000, 0, 1, 3'h0, 0, 0);
		i_crf_core_model.step(3'h0, 16'h0000, 16'h0000, 0, 0, 3'h0, 1, 0);
		chk(instruction_address_counter, 16'h0000);
		report_and_stop;
	end
endmodule
